// ### core/reset_pu_stop_supervisor.sv
// reset gating, operator unit unplug watch and panel stop control
// assumes synchronous inputs; trip/thermal logic sits outside
`include "supervisor_regs.svh"
module reset_pu_stop_supervisor #(
  parameter int UNPLUG_CYCLES = `UNPLUG_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     sel_wr,
  input  wire logic [4:0]               sel_wdata,
  input  wire logic                     param_clear,
  input  wire logic [7:0]               extended_display_select,
  input  wire logic                     tripped,
  input  wire logic                     running,
  input  wire supervisor_pkg::op_mode_t op_mode,
  input  wire logic                     reset_input_terminal,
  input  wire logic                     link_reset_cmd,
  input  wire logic                     unit_reset_key,
  input  wire logic                     unit_stop_key,
  input  wire logic                     unit_present,
  output logic [4:0]                    supervision_select,
  output logic                          sel_wr_refused,
  output logic                          reset_accept,
  output logic                          output_cutoff,
  output logic                          clear_accumulators,
  output logic                          unplug_trip,
  output logic                          fault_out,
  output logic [7:0]                    unit_unplug_fault_code,
  output logic                          decel_stop,
  output logic                          panel_stop_indication
);
  if (UNPLUG_CYCLES < 2) begin : g_bad_cycles
    $error("UNPLUG_CYCLES too small");
  end

  typedef struct packed {
    logic [4:0]  sel;
    logic        wr_refused;
    logic        accept;
    logic        cutoff;
    logic        clr_acc;
    logic        seen;
    logic        unplugged;
    logic [31:0] cnt;
    logic        decel;
    logic        pstop;
  } state_t;

  state_t s;
  state_t next_s;
  sel_if  d ();

  sel_decode u_dec (
    .sel (s.sel),
    .d   (d)
  );

  function automatic logic sel_legal(input logic [4:0] v);
    sel_legal = (v <= 5'h03) || (v >= 5'h0E && v <= 5'h11);
  endfunction

  logic ext_req;
  logic ext_ok;
  logic key_ok;
  logic stop_ok;
  logic timeout;

  always_comb begin
    next_s = s;
    ext_req = reset_input_terminal | link_reset_cmd;
    ext_ok  = ext_req & (d.reset_anytime | tripped);
    key_ok  = unit_reset_key & tripped;
    stop_ok = unit_stop_key &
              (d.stop_all_modes ||
               op_mode == supervisor_pkg::MODE_PANEL);
    timeout = (s.cnt >= 32'(UNPLUG_CYCLES));
    next_s.wr_refused = 1'b0;
    // param_clear has no effect on the selection on purpose
    if (sel_wr) begin
      if (extended_display_select == 8'h00 && sel_legal(sel_wdata))
        next_s.sel = sel_wdata;
      else
        next_s.wr_refused = 1'b1;
    end
    next_s.accept  = ext_ok | key_ok;
    next_s.cutoff  = (ext_ok | key_ok) & running;
    next_s.clr_acc = ext_ok | key_ok;
    // counter restarts on any sighting of the unit
    if (unit_present) begin
      next_s.seen = 1'b1;
      next_s.cnt  = '0;
    end else if (s.seen && !timeout) begin
      next_s.cnt = s.cnt + 32'h1;
    end
    if (ext_ok | key_ok)
      next_s.unplugged = 1'b0;
    // set after clear: a unit still missing outlasts the reset
    if (s.seen && timeout && d.unplug_trips)
      next_s.unplugged = 1'b1;
    next_s.decel = stop_ok;
    if ((reset_input_terminal & ext_ok) | key_ok)
      next_s.pstop = 1'b0;
    // panel stop latches only in the all-modes selections; a held key wins
    if (stop_ok && d.stop_all_modes)
      next_s.pstop = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s     <= '0;
      s.sel <= `SEL_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign supervision_select     = s.sel;
  assign sel_wr_refused         = s.wr_refused;
  assign reset_accept           = s.accept;
  assign output_cutoff          = s.cutoff;
  assign clear_accumulators     = s.clr_acc;
  assign unplug_trip            = s.unplugged;
  assign fault_out              = s.unplugged;
  assign unit_unplug_fault_code = s.unplugged ? `FAULT_UNPLUG
                                              : `FAULT_NONE;
  assign decel_stop             = s.decel;
  assign panel_stop_indication  = s.pstop;

  property p_sel_legal;
    @(posedge clk) disable iff (!rst_b) sel_legal(s.sel);
  endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("selection out of range");

  property p_gate;
    @(posedge clk) disable iff (!rst_b)
      (reset_input_terminal && !tripped && !unit_reset_key &&
       s.sel inside {5'h01, 5'h03, 5'h0F, 5'h11})
      |=> !reset_accept;
  endproperty
  a_gate: assert property (p_gate)
    else $error("reset accepted while not tripped");

  property p_anytime;
    @(posedge clk) disable iff (!rst_b)
      (link_reset_cmd && s.sel inside {5'h00, 5'h02, 5'h0E, 5'h10})
      |=> reset_accept;
  endproperty
  a_anytime: assert property (p_anytime)
    else $error("reset refused in anytime selection");

  property p_coast;
    @(posedge clk) disable iff (!rst_b)
      reset_accept |-> (output_cutoff == $past(running)) && clear_accumulators;
  endproperty
  a_coast: assert property (p_coast)
    else $error("cutoff or clear mismatch on reset");

  property p_key;
    @(posedge clk) disable iff (!rst_b)
      (unit_reset_key && !tripped && !reset_input_terminal && !link_reset_cmd)
      |=> !reset_accept;
  endproperty
  a_key: assert property (p_key)
    else $error("unit reset key honoured without trip");

  property p_no_unplug;
    @(posedge clk) disable iff (!rst_b)
      (s.sel inside {5'h00, 5'h01, 5'h0E, 5'h0F})
      |=> !unplug_trip || $past(unplug_trip);
  endproperty
  a_no_unplug: assert property (p_no_unplug)
    else $error("unplug fault in continue selection");

  property p_fault_code;
    @(posedge clk) disable iff (!rst_b)
      fault_out |-> unit_unplug_fault_code == `FAULT_UNPLUG;
  endproperty
  a_fault_code: assert property (p_fault_code)
    else $error("wrong fault code");

  property p_present_clears;
    @(posedge clk) disable iff (!rst_b)
      unit_present |=> s.cnt == 32'h0;
  endproperty
  a_present_clears: assert property (p_present_clears)
    else $error("counter not restarted");

  property p_locked;
    @(posedge clk) disable iff (!rst_b)
      (sel_wr && extended_display_select != 8'h00) |=> $stable(s.sel);
  endproperty
  a_locked: assert property (p_locked)
    else $error("selection written while locked");

  property p_panel_only;
    @(posedge clk) disable iff (!rst_b)
      (s.sel <= 5'h03 && op_mode != supervisor_pkg::MODE_PANEL)
      |=> !decel_stop;
  endproperty
  a_panel_only: assert property (p_panel_only)
    else $error("stop key acted outside panel mode");

  property p_keep;
    @(posedge clk) disable iff (!rst_b)
      (param_clear && !sel_wr) |=> $stable(s.sel);
  endproperty
  a_keep: assert property (p_keep)
    else $error("parameter clear moved the selection");

  property p_any_mode;
    @(posedge clk) disable iff (!rst_b)
      (unit_stop_key && s.sel inside {[5'h0E:5'h11]}) |=> decel_stop;
  endproperty
  a_any_mode: assert property (p_any_mode)
    else $error("stop key ignored in all-modes selection");

  sequence seq_timed_out;
    s.seen && (s.cnt >= 32'(UNPLUG_CYCLES));
  endsequence

  sequence seq_fault_up;
    unplug_trip && fault_out;
  endsequence

  property p_unplug_trip;
    @(posedge clk) disable iff (!rst_b)
      (seq_timed_out ##0 (s.sel inside {5'h02, 5'h03, 5'h10, 5'h11}))
      |=> seq_fault_up;
  endproperty
  a_unplug_trip: assert property (p_unplug_trip)
    else $error("unplug fault not raised");

  property p_pstop_clear;
    @(posedge clk) disable iff (!rst_b)
      (reset_input_terminal && !unit_stop_key &&
       (tripped || s.sel inside {5'h00, 5'h02, 5'h0E, 5'h10}))
      |=> !panel_stop_indication;
  endproperty
  a_pstop_clear: assert property (p_pstop_clear)
    else $error("accepted terminal reset left panel stop");

  property p_link_gate;
    @(posedge clk) disable iff (!rst_b)
      (link_reset_cmd && !tripped && !reset_input_terminal &&
       s.sel inside {5'h01, 5'h03, 5'h0F, 5'h11}) |=> !reset_accept;
  endproperty
  a_link_gate: assert property (p_link_gate)
    else $error("link reset accepted while not tripped");
endmodule

// ### core/sel_decode.sv
// decodes the supervision selection into three behaviour bits
// assumes the value has already been range checked
module sel_decode (
  input  wire logic [4:0] sel,
  sel_if.dec              d
);
  // 14..17 repeat the 0..3 pattern, plus the stop key in every mode
  logic       all_modes;
  logic [4:0] idx;
  assign all_modes        = (sel >= 5'h0E);
  assign idx              = all_modes ? sel - 5'h0E : sel;
  assign d.reset_anytime  = ~idx[0];
  assign d.unplug_trips   = idx[1];
  assign d.stop_all_modes = all_modes;
endmodule

// ### core/sel_if.sv
// selection decode carried from decoder to supervisor
// assumes one producer and one consumer
interface sel_if;
  logic reset_anytime;
  logic unplug_trips;
  logic stop_all_modes;
  modport dec (output reset_anytime, output unplug_trips,
               output stop_all_modes);
  modport use_ (input reset_anytime, input unplug_trips,
                input stop_all_modes);
endinterface

// ### core/supervisor_pkg.sv
// types of the reset / unplug / panel-stop supervisor
// assumes nothing beyond the constants header
package supervisor_pkg;
  typedef enum logic [1:0] {
    MODE_PANEL,
    MODE_EXTERNAL,
    MODE_NETWORK
  } op_mode_t;
endpackage

// ### core/supervisor_regs.svh
// constants of the reset / unit-unplug / panel-stop supervisor
// assumes a 125 MHz system clock and synchronous panel inputs
// How it works
// - selection takes only 0..3 and 14..17; starts at 14.
// - selections 1,3,15,17 accept reset only while tripped.
// - selections 0,2,14,16 accept reset at any time.
// - selections 2,3,16,17 trip once the unit is judged unplugged.
// - unplug declared after absence above one second; fault code and trip raised together.
// - selections 0,1,14,15 ignore an unplugged unit, no fault.
// - selections 0..3 stop key decelerates only in panel mode.
// - selections 14..17 stop key decelerates in every mode.
// - acceptance condition covers terminal reset and link reset command.
// - accepted reset while running cuts output at once, motor coasts.
// - accepted reset clears thermal and brake duty accumulators.
// - unit reset key honoured only while tripped, any selection.
// - selection writable whether running or tripped; parameter clears leave it alone.
// - selection writable only while extended display select is 0.
// - panel stop shows its indication only in selections 14..17 and raises no fault.
// - unit absent since power-on is not an unplug fault.
// - power reset or accepted terminal reset clears panel stop.
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH
`define SEL_INIT         5'h0E
`define CLK_HZ           125000000
`define UNPLUG_TIME_MS   1000
`define UNPLUG_CYCLES    (`CLK_HZ / 1000 * `UNPLUG_TIME_MS)
`define FAULT_UNPLUG     8'h01
`define FAULT_NONE       8'h00
`endif

// ### test/reset_pu_stop_supervisor_tb.sv
// bench for the reset / unplug / panel stop supervisor
// assumes unplug count shortened to 20 clocks
module reset_pu_stop_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, sel_wr = 0, param_clear = 0;
  logic [4:0] sel_wdata = 5'h00;
  logic [7:0] extended_display_select = 8'h00;
  logic tripped = 0, running = 0, plug = 0, stop = 0, rkey = 0;
  supervisor_pkg::op_mode_t op_mode = supervisor_pkg::MODE_PANEL;
  logic reset_input_terminal = 0, link_reset_cmd = 0;
  logic unit_reset_key, unit_stop_key, unit_present;
  logic [4:0] supervision_select;
  logic sel_wr_refused, reset_accept, output_cutoff;
  logic clear_accumulators, unplug_trip, fault_out;
  logic decel_stop, panel_stop_indication;
  logic [7:0] unit_unplug_fault_code;
  int fails = 0, comparisons = 0, cyc = 0;
  reset_pu_stop_supervisor #(.UNPLUG_CYCLES(20)) u_reset_pu_stop_supervisor (
    .clk, .rst_b, .sel_wr, .sel_wdata, .param_clear,
    .extended_display_select, .tripped, .running, .op_mode,
    .reset_input_terminal, .link_reset_cmd, .unit_reset_key,
    .unit_stop_key, .unit_present, .supervision_select,
    .sel_wr_refused, .reset_accept, .output_cutoff,
    .clear_accumulators, .unplug_trip, .fault_out,
    .unit_unplug_fault_code, .decel_stop, .panel_stop_indication);
  unit_model u_unit_model (.clk, .plug, .stop, .rkey, .unit_present,
    .unit_stop_key, .unit_reset_key);
  initial forever #4 clk = ~clk;
  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(logic ok, string m);
    comparisons++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(logic [4:0] v, logic rf);
    sel_wdata = v;
    sel_wr = 1;
    step(1);
    chk(sel_wr_refused === rf, "write refusal");
    sel_wr = 0;
    step(1);
  endtask
  task automatic req(logic t, logic l, logic e);
    reset_input_terminal = t;
    link_reset_cmd = l;
    step(1);
    chk(reset_accept === e, "reset acceptance");
    chk(clear_accumulators === e, "accumulator clear");
    chk(output_cutoff === (e & running), "output cutoff");
    reset_input_terminal = 0;
    link_reset_cmd = 0;
    step(1);
  endtask
  task automatic key_reset(logic e);
    rkey = 1;
    step(2);
    chk(reset_accept === e, "unit reset key");
    rkey = 0;
    step(2);
  endtask
  task automatic t_select();
    chk(supervision_select === 5'h0E, "initial selection");
    wr(5'h05, 1);
    wr(5'h12, 1);
    extended_display_select = 8'h01;
    wr(5'h0F, 1);
    chk(supervision_select === 5'h0E, "locked write");
    extended_display_select = 8'h00;
    wr(5'h11, 0);
    param_clear = 1;
    step(1);
    param_clear = 0;
    step(1);
    chk(supervision_select === 5'h11, "param clear");
  endtask
  task automatic t_reset();
    plug = 1;
    wr(5'h0F, 0);
    req(1, 0, 0);
    req(0, 1, 0);
    key_reset(0);
    tripped = 1;
    running = 1;
    req(1, 0, 1);
    req(0, 1, 1);
    key_reset(1);
    tripped = 0;
    running = 0;
    wr(5'h0E, 0);
    req(1, 0, 1);
    req(0, 1, 1);
    key_reset(0);
  endtask
  task automatic t_stop();
    plug = 1;
    wr(5'h00, 0);
    op_mode = supervisor_pkg::MODE_EXTERNAL;
    stop = 1;
    step(3);
    chk(decel_stop === 0, "stop outside panel mode");
    op_mode = supervisor_pkg::MODE_PANEL;
    step(2);
    chk(decel_stop === 1, "stop in panel mode");
    stop = 0;
    wr(5'h0E, 0);
    op_mode = supervisor_pkg::MODE_NETWORK;
    stop = 1;
    step(3);
    chk(decel_stop === 1, "stop in any mode");
    chk(panel_stop_indication === 1, "panel stop shown");
    chk(fault_out === 0, "no fault on panel stop");
    stop = 0;
    step(2);
    req(1, 0, 1);
    chk(panel_stop_indication === 0, "panel stop cleared");
  endtask
  task automatic t_unplug();
    plug = 0;
    step(3);
    plug = 1;
    wr(5'h10, 0);
    step(2);
    plug = 0;
    step(21);
    chk(fault_out === 0, "unplug too early");
    step(1);
    chk(fault_out === 1 && unplug_trip === 1, "unplug trip");
    chk(unit_unplug_fault_code === 8'h01, "fault code");
    plug = 1;
    step(2);
    req(1, 0, 1);
    chk(fault_out === 0, "fault cleared");
    wr(5'h0E, 0);
    step(2);
    plug = 0;
    step(30);
    chk(fault_out === 0 && unplug_trip === 0, "unplug ignored");
  endtask
  task automatic t_power();
    wr(5'h10, 0);
    stop = 1;
    step(3);
    chk(panel_stop_indication === 1, "panel stop latched");
    stop = 0;
    rst_b = 0;
    step(2);
    chk(panel_stop_indication === 0, "power reset clears stop");
    rst_b = 1;
    step(1);
    chk(supervision_select === 5'h0E, "selection after reset");
  endtask
  task automatic t_low_trip();
    wr(5'h03, 0);
    chk(fault_out === 1, "unplug trip in selection 3");
    req(1, 0, 0);
    plug = 1;
    step(2);
    tripped = 1;
    req(0, 1, 1);
    chk(fault_out === 0, "fault cleared at 3");
    tripped = 0;
    wr(5'h11, 0);
    op_mode = supervisor_pkg::MODE_EXTERNAL;
    stop = 1;
    step(3);
    chk(decel_stop === 1, "stop in external mode at 17");
    stop = 0;
    req(0, 1, 0);
  endtask
  initial begin
    step(10);
    rst_b = 1;
    step(1);
    t_select();
    wr(5'h10, 0);
    step(30);
    chk(fault_out === 0, "absent since power on");
    t_reset();
    t_stop();
    t_power();
    t_unplug();
    t_low_trip();
    close_out();
  end
endmodule

// ### test/unit_model.sv
// operator unit stand-in: presence and the two keys
// assumes bench commands change just after a clock edge
module unit_model (
  input  wire logic clk,
  input  wire logic plug,
  input  wire logic stop,
  input  wire logic rkey,
  output logic      unit_present = 1'b0,
  output logic      unit_stop_key = 1'b0,
  output logic      unit_reset_key = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // an unplugged unit cannot hold a key down
  always @(posedge clk) begin
    unit_present   <= plug;
    unit_stop_key  <= plug & stop;
    unit_reset_key <= plug & rkey;
  end
endmodule
